/* verilog/mor_channel_config.sv */
`timescale 1ns/10ps
`include "mor_consts.svh"

// How it works
// - voltage code: 0.8 V plus 50 mV steps
// - control bit 6 picks buck-only mode
// - current limit codes map to four amp values
// - discharge resistor on when disabled and enabled
// - discharge off keeps resistor disconnected
// - enable codes 0-3 follow sequencer slot
// - codes 4 and 5 force channel off
// - codes 6 and 7 force channel on
// - channel 1 uses same voltage code
// - channel 1 control mirrors channel 0 fields

module mor_channel_config
(
    // clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    // register port from the serial interface
    input  wire logic [7:0]                  i_reg_addr,
    input  wire logic                        i_reg_wr,
    input  wire logic                        i_reg_rd,
    input  wire logic [7:0]                  i_reg_wdata,
    output      logic [7:0]                  o_reg_rdata,
    output      logic                        o_reg_rvalid,
    // factory defaults from one-time memory
    input  wire mor_pkg::mor_chan_cfg_t [1:0] i_otp_cfg,
    // power sequencer slot states
    input  wire logic [3:0]                  i_seq_slot_on,
    // decoded controls per channel, index 0 and 1
    output      mor_pkg::mor_chan_out_t [1:0] o_ch_out,
    output      logic                        o_cfg_ready
);

    mor_pkg::mor_top_state_t        s_r;
    mor_pkg::mor_top_state_t        s_nxt;
    mor_pkg::mor_chan_out_t [1:0]   dec_out;

    // register read mux; unmapped addresses answer zero
    function automatic logic [7:0] mor_read_reg(input mor_pkg::mor_chan_cfg_t [1:0] cfg,
                                                input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        case (addr)
            `MOR_OFS_CH0_TV:   val = {1'b0, cfg[0].tv};
            `MOR_OFS_CH0_CTRL: val = {1'b0, cfg[0].ctrl};
            `MOR_OFS_CH1_TV:   val = {1'b0, cfg[1].tv};
            `MOR_OFS_CH1_CTRL: val = {1'b0, cfg[1].ctrl};
            default:           val = 8'h00;
        endcase
        return val;
    endfunction: mor_read_reg

    // one decoder per channel, same encodings for both
    mor_chan_decode u_dec0
    (
        .i_cfg     (s_r.cfg[0]),
        .i_slot_on (i_seq_slot_on),
        .o_out     (dec_out[0])
    );

    mor_chan_decode u_dec1
    (
        .i_cfg     (s_r.cfg[1]),
        .i_slot_on (i_seq_slot_on),
        .o_out     (dec_out[1])
    );

    // next state: default copy, load defaults once, then serve accesses
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.rvalid = 1'b0;
        case (s_r.state)
            mor_pkg::MOR_LOAD:
            begin
                // copied after release, never under reset itself
                s_nxt.cfg   = i_otp_cfg;
                s_nxt.state = mor_pkg::MOR_RUN;
            end
            mor_pkg::MOR_RUN:
            begin
                if (i_reg_rd)
                begin
                    // read sees the value before a same-cycle write
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rdata  = mor_read_reg(s_r.cfg, i_reg_addr);
                end
                if (i_reg_wr)
                begin
                    case (i_reg_addr)
                        // bit 7 dropped on the floor
                        `MOR_OFS_CH0_TV:   s_nxt.cfg[0].tv   = i_reg_wdata[6:0];
                        `MOR_OFS_CH0_CTRL: s_nxt.cfg[0].ctrl = i_reg_wdata[6:0];
                        `MOR_OFS_CH1_TV:   s_nxt.cfg[1].tv   = i_reg_wdata[6:0];
                        `MOR_OFS_CH1_CTRL: s_nxt.cfg[1].ctrl = i_reg_wdata[6:0];
                        default:           s_nxt.cfg         = s_r.cfg;
                    endcase
                end
            end
            default:
            begin
                s_nxt.state = mor_pkg::MOR_LOAD;
            end
        endcase
        // outputs held off until defaults are in; a zero config would mean slot 0
        if (s_r.state == mor_pkg::MOR_RUN)
        begin
            s_nxt.out = dec_out;
        end
        else
        begin
            s_nxt.out = '0;
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_r.state  <= mor_pkg::MOR_LOAD;
            s_r.cfg    <= {`MOR_CFG_RESET, `MOR_CFG_RESET};
            s_r.rdata  <= 8'h00;
            s_r.rvalid <= 1'b0;
            s_r.out    <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign o_reg_rdata  = s_r.rdata;
    assign o_reg_rvalid = s_r.rvalid;
    assign o_ch_out     = s_r.out;
    assign o_cfg_ready  = (s_r.state == mor_pkg::MOR_RUN);

    // checks on the registered outputs and the stored fields
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_ch0_vout_code: assert property (
        (s_r.state == mor_pkg::MOR_RUN) |=>
            o_ch_out[0].vout_mv == `MOR_TV_BASE_MV + `MOR_TV_STEP_MV * {6'h00, $past(s_r.cfg[0].tv)})
        else $error("channel 0 voltage decode wrong");

    a_tv_reserved_flag: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].tv > `MOR_TV_MAX_CODE) |=> o_ch_out[0].tv_reserved)
        else $error("reserved voltage code not flagged");

    a_ctrl_bit7_zero: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH0_CTRL) && o_cfg_ready |=> o_reg_rvalid && !o_reg_rdata[7])
        else $error("control bit 7 read not zero");

    a_mode_select: assert property (
        (s_r.state == mor_pkg::MOR_RUN) |=> o_ch_out[0].buck_only == $past(s_r.cfg[0].ctrl.buck_only))
        else $error("mode bit not passed through");

    a_ilim_top_code: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].ctrl.ilim == 2'h3) |=>
            o_ch_out[0].ilim_ma == `MOR_ILIM_CODE3_MA)
        else $error("current limit code 3 wrong");

    a_ilim_low_code: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].ctrl.ilim == 2'h0) |=>
            o_ch_out[0].ilim_ma == `MOR_ILIM_CODE0_MA)
        else $error("current limit code 0 wrong");

    a_discharge_on: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && s_r.cfg[0].ctrl.ade |=>
            o_ch_out[0].discharge == !o_ch_out[0].enable)
        else $error("discharge not tied to disable");

    a_discharge_off: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && !s_r.cfg[0].ctrl.ade |=> !o_ch_out[0].discharge)
        else $error("discharge active while not enabled");

    a_slot_follow: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && !s_r.cfg[0].ctrl.en[2] |=>
            o_ch_out[0].enable == $past(i_seq_slot_on[s_r.cfg[0].ctrl.en[1:0]]))
        else $error("slot enable does not follow sequencer");

    a_force_off: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].ctrl.en[2:1] == 2'h2) |=> !o_ch_out[0].enable)
        else $error("forced off channel enabled");

    a_force_on: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].ctrl.en[2:1] == 2'h3) |=> o_ch_out[0].enable)
        else $error("forced on channel disabled");

    a_ch1_vout_code: assert property (
        (s_r.state == mor_pkg::MOR_RUN) |=>
            o_ch_out[1].vout_mv == `MOR_TV_BASE_MV + `MOR_TV_STEP_MV * {6'h00, $past(s_r.cfg[1].tv)})
        else $error("channel 1 voltage decode wrong");

    a_ch1_ctrl_decode: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[1].ctrl.en[2:1] == 2'h3) |=>
            o_ch_out[1].enable && (o_ch_out[1].buck_only == $past(s_r.cfg[1].ctrl.buck_only)))
        else $error("channel 1 control decode wrong");

    a_otp_load: assert property (
        (s_r.state == mor_pkg::MOR_LOAD) |=> o_cfg_ready && (s_r.cfg == $past(i_otp_cfg)))
        else $error("factory defaults not loaded");

    a_tv_bit7_zero: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH0_TV) && o_cfg_ready |=> o_reg_rvalid && !o_reg_rdata[7])
        else $error("voltage bit 7 read not zero");

    a_ilim_code1: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].ctrl.ilim == 2'h1) |=>
            o_ch_out[0].ilim_ma == `MOR_ILIM_CODE1_MA)
        else $error("current limit code 1 wrong");

    a_ilim_code2: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].ctrl.ilim == 2'h2) |=>
            o_ch_out[0].ilim_ma == `MOR_ILIM_CODE2_MA)
        else $error("current limit code 2 wrong");

    a_tv_legal_clear: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[0].tv <= `MOR_TV_MAX_CODE) |=>
            !o_ch_out[0].tv_reserved)
        else $error("legal voltage code flagged reserved");

    a_ch0_tv_write: assert property (
        i_reg_wr && (i_reg_addr == `MOR_OFS_CH0_TV) && o_cfg_ready |=>
            s_r.cfg[0].tv == $past(i_reg_wdata[6:0]))
        else $error("channel 0 voltage write not stored");

    a_ch0_ctrl_write: assert property (
        i_reg_wr && (i_reg_addr == `MOR_OFS_CH0_CTRL) && o_cfg_ready |=>
            s_r.cfg[0].ctrl == $past(i_reg_wdata[6:0]))
        else $error("channel 0 control write not stored");

    a_ch0_tv_readback: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH0_TV) && o_cfg_ready |=>
            o_reg_rvalid && (o_reg_rdata == {1'b0, $past(s_r.cfg[0].tv)}))
        else $error("channel 0 voltage readback wrong");

    a_ch0_ctrl_readback: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH0_CTRL) && o_cfg_ready |=>
            o_reg_rvalid && (o_reg_rdata[6:0] == $past(s_r.cfg[0].ctrl)))
        else $error("channel 0 control readback wrong");

    a_ch1_tv_readback: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH1_TV) && o_cfg_ready |=>
            o_reg_rvalid && (o_reg_rdata[6:0] == $past(s_r.cfg[1].tv)))
        else $error("channel 1 voltage readback wrong");

    a_ch1_tv_bit7: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH1_TV) && o_cfg_ready |=>
            o_reg_rvalid && !o_reg_rdata[7])
        else $error("channel 1 voltage bit 7 read not zero");

    a_ch1_ctrl_bit7: assert property (
        i_reg_rd && (i_reg_addr == `MOR_OFS_CH1_CTRL) && o_cfg_ready |=>
            o_reg_rvalid && !o_reg_rdata[7])
        else $error("channel 1 control bit 7 read not zero");

    a_ch1_tv_reserved: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[1].tv > `MOR_TV_MAX_CODE) |=>
            o_ch_out[1].tv_reserved)
        else $error("channel 1 reserved voltage not flagged");

    a_ch1_mode: assert property (
        (s_r.state == mor_pkg::MOR_RUN) |=>
            o_ch_out[1].buck_only == $past(s_r.cfg[1].ctrl.buck_only))
        else $error("channel 1 mode bit not passed through");

    a_ch1_ilim_top: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[1].ctrl.ilim == 2'h3) |=>
            o_ch_out[1].ilim_ma == `MOR_ILIM_CODE3_MA)
        else $error("channel 1 current limit code 3 wrong");

    a_ch1_discharge_on: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && s_r.cfg[1].ctrl.ade |=>
            o_ch_out[1].discharge == !o_ch_out[1].enable)
        else $error("channel 1 discharge not tied to disable");

    a_ch1_discharge_off: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && !s_r.cfg[1].ctrl.ade |=>
            !o_ch_out[1].discharge)
        else $error("channel 1 discharge active while not enabled");

    a_ch1_slot_follow: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && !s_r.cfg[1].ctrl.en[2] |=>
            o_ch_out[1].enable == $past(i_seq_slot_on[s_r.cfg[1].ctrl.en[1:0]]))
        else $error("channel 1 slot enable does not follow sequencer");

    a_ch1_force_off: assert property (
        (s_r.state == mor_pkg::MOR_RUN) && (s_r.cfg[1].ctrl.en[2:1] == 2'h2) |=>
            !o_ch_out[1].enable)
        else $error("channel 1 forced off but enabled");

    a_load_outputs_off: assert property (
        (s_r.state == mor_pkg::MOR_LOAD) |=>
            (o_ch_out == '0))
        else $error("outputs active before defaults loaded");

endmodule: mor_channel_config

/* verilog/mor_consts.svh */
`ifndef MOR_CONSTS_SVH
`define MOR_CONSTS_SVH

// register offsets on the serial register port
`define MOR_OFS_CH0_TV          8'h29
`define MOR_OFS_CH0_CTRL        8'h2a
`define MOR_OFS_CH1_TV          8'h2b
`define MOR_OFS_CH1_CTRL        8'h2c

// field positions inside the register bytes
`define MOR_UNUSED_BIT          7
`define MOR_TV_MSB              6
`define MOR_TV_LSB              0
`define MOR_MODE_BIT            6
`define MOR_ILIM_MSB            5
`define MOR_ILIM_LSB            4
`define MOR_ADE_BIT             3
`define MOR_EN_MSB              2
`define MOR_EN_LSB              0

// enable field decode: bit 2 set means forced, bit 1 then picks on or off
`define MOR_EN_FORCE_BIT        2
`define MOR_EN_ONOFF_BIT        1

// reset value of the stored fields before the factory defaults are copied
`define MOR_CFG_RESET           14'h0000

// target voltage transfer function, millivolts
`define MOR_TV_BASE_MV          13'h0320
`define MOR_TV_STEP_MV          13'h0032
`define MOR_TV_MAX_CODE         7'h5e

// peak current limit per code, milliamps
`define MOR_ILIM_CODE0_MA       16'h03e8
`define MOR_ILIM_CODE1_MA       16'h02ee
`define MOR_ILIM_CODE2_MA       16'h01f4
`define MOR_ILIM_CODE3_MA       16'h014d

`endif

/* verilog/mor_pkg.sv */
package mor_pkg;

    // control byte fields below the unused bit
    typedef struct packed {
        logic       buck_only;
        logic [1:0] ilim;
        logic       ade;
        logic [2:0] en;
    } mor_ctrl_t;

    // everything stored for one channel
    typedef struct packed {
        logic [6:0] tv;
        mor_ctrl_t  ctrl;
    } mor_chan_cfg_t;

    // decoded view handed to the analog side
    typedef struct packed {
        logic        enable;
        logic        discharge;
        logic        buck_only;
        logic [15:0] ilim_ma;
        logic [12:0] vout_mv;
        logic        tv_reserved;
    } mor_chan_out_t;

    typedef enum logic {
        MOR_LOAD = 1'b0,
        MOR_RUN  = 1'b1
    } mor_state_t;

    typedef struct packed {
        mor_state_t               state;
        mor_chan_cfg_t [1:0]      cfg;
        logic [7:0]               rdata;
        logic                     rvalid;
        mor_chan_out_t [1:0]      out;
    } mor_top_state_t;

endpackage: mor_pkg

/* verilog/mor_chan_decode.sv */
`timescale 1ns/10ps
`include "mor_consts.svh"

module mor_chan_decode
(
    // stored channel configuration
    input  wire mor_pkg::mor_chan_cfg_t i_cfg,
    // sequencer slot states, one bit per slot
    input  wire logic [3:0]             i_slot_on,
    // decoded channel controls
    output      mor_pkg::mor_chan_out_t o_out
);

    // purely combinational; the top registers the result
    always_comb
    begin
        o_out              = '0;
        o_out.buck_only    = i_cfg.ctrl.buck_only;
        // linear code: base plus one step per count
        o_out.vout_mv      = `MOR_TV_BASE_MV + `MOR_TV_STEP_MV * {6'h00, i_cfg.tv};
        // reserved codes flagged, not clamped, so software slips stay visible
        o_out.tv_reserved  = (i_cfg.tv > `MOR_TV_MAX_CODE);
        case (i_cfg.ctrl.ilim)
            2'h0: o_out.ilim_ma = `MOR_ILIM_CODE0_MA;
            2'h1: o_out.ilim_ma = `MOR_ILIM_CODE1_MA;
            2'h2: o_out.ilim_ma = `MOR_ILIM_CODE2_MA;
            default: o_out.ilim_ma = `MOR_ILIM_CODE3_MA;
        endcase
        // forced codes override the sequencer, slot codes follow it
        if (i_cfg.ctrl.en[`MOR_EN_FORCE_BIT])
        begin
            o_out.enable = i_cfg.ctrl.en[`MOR_EN_ONOFF_BIT];
        end
        else
        begin
            o_out.enable = i_slot_on[i_cfg.ctrl.en[1:0]];
        end
        // resistor only while disabled and enabled by software
        o_out.discharge    = i_cfg.ctrl.ade & ~o_out.enable;
    end

endmodule: mor_chan_decode

/* test/mor_channel_config_test.sv */
`timescale 1ns/10ps

module mor_channel_config_test;

    logic                         clk;
    logic                         reset_n;
    logic [7:0]                   reg_addr;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [7:0]                   reg_wdata;
    logic [7:0]                   reg_rdata;
    logic                         reg_rvalid;
    mor_pkg::mor_chan_cfg_t [1:0] otp_cfg;
    logic [3:0]                   slot_on;
    mor_pkg::mor_chan_out_t [1:0] ch_out;
    logic                         cfg_ready;
    logic [6:0]                   m [0:3];
    logic [6:0]                   tvs [0:4];
    logic [31:0]                  seed;
    logic [31:0]                  r;
    logic [3:0]                   s;
    logic [7:0]                   a;
    logic [7:0]                   d;
    int                           miscompares;
    int                           comparisons;
    int                           cycles = 0;

    mor_channel_config i_dut
    (
        .i_clk         (clk),
        .i_reset_n     (reset_n),
        .i_reg_addr    (reg_addr),
        .i_reg_wr      (reg_wr),
        .i_reg_rd      (reg_rd),
        .i_reg_wdata   (reg_wdata),
        .o_reg_rdata   (reg_rdata),
        .o_reg_rvalid  (reg_rvalid),
        .i_otp_cfg     (otp_cfg),
        .i_seq_slot_on (slot_on),
        .o_ch_out      (ch_out),
        .o_cfg_ready   (cfg_ready)
    );

    // 25 MHz clock
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // xorshift source, fixed seed keeps runs repeatable
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction: rnd

    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask: chk

    // expected decode of one channel from its stored bytes
    function automatic mor_pkg::mor_chan_out_t exp_out(input logic [6:0] tv, input logic [6:0] c);
        mor_pkg::mor_chan_out_t e;
        e.enable      = c[2] ? c[1] : slot_on[c[1:0]];
        e.discharge   = c[3] & ~e.enable;
        e.buck_only   = c[6];
        e.ilim_ma     = c[5] ? (c[4] ? 16'h014d : 16'h01f4) : (c[4] ? 16'h02ee : 16'h03e8);
        e.vout_mv     = 13'h0320 + 13'h0032 * {6'h00, tv};
        e.tv_reserved = (tv > 7'h5e);
        return e;
    endfunction: exp_out

    task automatic chk_out();
        chk("ch0_out", ch_out[0], exp_out(m[0], m[1]));
        chk("ch1_out", ch_out[1], exp_out(m[2], m[3]));
    endtask: chk_out

    // one access, strobes held for exactly one edge; read sees the old value
    task automatic acc(input logic wr, input logic rd, input logic [7:0] ad, input logic [7:0] d,
                       input logic [3:0] sl);
        logic       hit;
        logic [7:0] exp_rd;
        hit    = (ad >= 8'h29) && (ad <= 8'h2c);
        exp_rd = hit ? {1'b0, m[ad - 8'h29]} : 8'h00;
        @(negedge clk);
        reg_wr    = wr;
        reg_rd    = rd;
        reg_addr  = ad;
        reg_wdata = d;
        slot_on   = sl;
        @(negedge clk);
        if (rd)
        begin
            chk("rvalid", reg_rvalid, 33'h1);
            chk("rdata", reg_rdata, exp_rd);
        end
        if (wr && hit)
            m[ad - 8'h29] = d[6:0];
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        r         = rnd();
        reg_addr  = r[7:0];
        reg_wdata = r[15:8];
        @(negedge clk);
        chk("rvalid_pulse", reg_rvalid, 33'h0);
        chk_out();
    endtask: acc

    // reset with fresh factory defaults; a write at the first edge must be dropped
    task automatic do_reset();
        @(negedge clk);
        reset_n = 1'b0;
        r       = rnd();
        otp_cfg = r[27:0];
        otp_cfg[0].tv = 7'h5f | r[6:0]; // factory value is always reserved, software never writes one
        repeat (4) @(negedge clk);
        chk("ready_in_reset", cfg_ready, 33'h0);
        chk("out_in_reset", ch_out[0] | ch_out[1], 33'h0);
        m[0]      = otp_cfg[0].tv;
        m[1]      = otp_cfg[0].ctrl;
        m[2]      = otp_cfg[1].tv;
        m[3]      = otp_cfg[1].ctrl;
        reset_n   = 1'b1;
        reg_wr    = 1'b1;
        reg_addr  = 8'h29;
        reg_wdata = {1'b0, ~m[0]};
        @(negedge clk);
        reg_wr = 1'b0;
        chk("ready", cfg_ready, 33'h1);
        chk("out_first_edge", ch_out[0] | ch_out[1], 33'h0);
        @(negedge clk);
        chk_out();
        for (int i = 0; i < 4; i++)
            acc(1'b0, 1'b1, 8'h29 + i[7:0], 8'h00, slot_on);
    endtask: do_reset

    task print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask: print_verdict

    // hang guard, far above the roughly 1100 cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        seed        = 32'hd791aeae;
        miscompares = 0;
        comparisons = 0;
        reset_n     = 1'b0;
        reg_addr    = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_wdata   = 8'h00;
        otp_cfg     = '0;
        slot_on     = 4'h0;
        tvs         = '{7'h00, 7'h01, 7'h2f, 7'h5d, 7'h5e}; // legal codes only
        do_reset();
        $display("test reset done");
        // every enable code against idle, full and random slot states
        for (int en = 0; en < 8; en++)
            for (int k = 0; k < 3; k++)
            begin
                r = rnd();
                s = (k == 0) ? 4'h0 : ((k == 1) ? 4'hf : r[11:8]);
                acc(1'b1, 1'b0, 8'h2a, {1'b0, k[0], en[1:0], 1'b1, en[2:0]}, s);
                acc(1'b1, 1'b1, 8'h2c, {1'b0, ~k[0], r[1:0], k[0], en[2:0]}, s);
            end
        $display("test enable codes done");
        // voltage code edges, bit 7 set to show it is dropped
        for (int i = 0; i < 5; i++)
        begin
            acc(1'b1, 1'b1, 8'h29, {1'b1, tvs[i]}, slot_on);
            acc(1'b1, 1'b1, 8'h2b, {1'b1, tvs[4 - i]}, slot_on);
        end
        acc(1'b0, 1'b1, 8'h29, 8'h00, slot_on);
        $display("test voltage corners done");
        // random traffic, unmapped addresses among it
        repeat (300)
        begin
            r = rnd();
            a = r[2] ? (8'h29 + {6'h00, r[1:0]}) : r[15:8];
            d = r[23:16];
            // software keeps control bit 7 low and voltage codes legal
            if ((a == 8'h2a) || (a == 8'h2c))
                d[7] = 1'b0;
            if (((a == 8'h29) || (a == 8'h2b)) && (d[6:0] > 7'h5e))
                d[6] = 1'b0;
            acc(r[3], r[4] | ~r[3], a, d, r[27:24]);
        end
        $display("test random traffic done");
        do_reset();
        $display("test second reset done");
        print_verdict();
    end

endmodule: mor_channel_config_test
